// File: swdt_pkg.sv
// package for the supervisor timer: addresses, keys, field positions, reset values, timing
package swdt_pkg;
  // byte addresses on the peripheral bus (lower 16 bits)
  localparam logic [15:0] SWDT_ADDR_CSR_WR  = 16'hffa8;
  localparam logic [15:0] SWDT_ADDR_CSR_RD  = 16'hffa8;
  localparam logic [15:0] SWDT_ADDR_CNT_RD  = 16'hffa9;
  localparam logic [15:0] SWDT_ADDR_RST_WR  = 16'hffaa;
  localparam logic [15:0] SWDT_ADDR_RST_RD  = 16'hffab;
  // write keys in the high byte of a word write
  localparam logic [7:0]  SWDT_KEY_CNT      = 8'h5a;
  localparam logic [7:0]  SWDT_KEY_CSR      = 8'ha5;
  localparam logic [7:0]  SWDT_RST_CLR_DATA = 8'h00;
  // control/status fields
  localparam int          SWDT_OVERFLOW_BIT = 7;
  localparam int          SWDT_MODE_BIT     = 6;
  localparam int          SWDT_EN_BIT       = 5;
  localparam logic [1:0]  SWDT_CSR_ONES     = 2'h3;
  localparam logic [7:0]  SWDT_CSR_RESET    = 8'h18;
  localparam logic [7:0]  SWDT_CNT_RESET    = 8'h00;
  localparam logic [7:0]  SWDT_CNT_MAX      = 8'hff;
  // reset-status: flag in bit 7, bits 5..0 read as ones
  localparam int          SWDT_WD_FLAG_BIT  = 7;
  localparam logic [6:0]  SWDT_RST_LOW_READ = 7'h3f;
  // prescaler
  localparam int          SWDT_PRE_W        = 12;
  // internal reset length, in states (clock cycles)
  localparam int          SWDT_RST_STATES   = 518;
  localparam int          SWDT_RST_CNT_W    = 10;
  // reset-pulse sequencer
  typedef enum logic [0:0] {
    SWDT_IDLE  = 1'b0,
    SWDT_PULSE = 1'b1
  } swdt_state_type;
endpackage : swdt_pkg

// File: swdt_top.sv
// supervisor timer: prescaler, 8-bit counter, keyed registers and internal reset pulse
//
// Summary of operation
// - with enable set, counter advances once per selected prescaler pulse
// - rollover from ff to 00 sets the overflow flag
// - enable clear or reset holds counter at zero
// - clock-select codes pick phi/2,32,64,128,256,512,2048,4096
// - overflow flag clears by writing 0 after reading 1; writing 1 does nothing
// - mode bit: 0 interval interrupt, 1 internal reset on overflow
// - control/status bits 4 and 3 read as one
// - bits 7..5 cleared by reset and standby; bits 2..0 only by reset
// - word write at one address; key 5a loads counter, a5 loads control/status
// - byte writes to counter or control/status are ignored
// - word write a5 00 to reset-status address clears watchdog-reset flag
// - byte reads: control/status ffa8, counter ffa9, reset status ffab
// - watchdog-mode overflow asserts internal chip reset for 518 states
// - external reset pin wins over a simultaneous watchdog reset
// - watchdog overflow sets both flags; internal reset clears only overflow
// - watchdog-reset flag cleared by pin reset, kept by own reset
// - watchdog-reset flag cleared by 0 after reading 1; never set by software
// - in interval mode, interrupt raised while overflow flag and enable are both 1
// - watchdog-reset flag set only with mode and enable both 1
// - a write coinciding with a count pulse wins; increment skipped
`timescale 1ns/1ps
module swdt_top
  import swdt_pkg::*;
#(
  parameter int RST_STATES = swdt_pkg::SWDT_RST_STATES
) (
  // clock and pin reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // system state
  input  wire logic        standby_i,
  // peripheral bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_word_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [7:0]  bus_rdata_o,
  // outputs to the chip
  output logic             interval_irq_o,
  output logic             chip_reset_o
);
  import swdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]              wd_counter;
  logic                    overflow_flag;
  logic                    watchdog_mode_select;
  logic                    counter_enable;
  logic [2:0]              clock_select;
  logic                    watchdog_reset_flag;
  logic                    overflow_seen;
  logic                    wd_flag_seen;
  logic [SWDT_PRE_W-1:0]   prescaler;
  logic [SWDT_RST_CNT_W-1:0] rst_count;
  swdt_state_type          state;
  swdt_state_type          next_state;
  logic                    int_rst;
  logic                    tick;
  logic                    wr_cnt;
  logic                    wr_csr;
  logic                    wr_rst;
  logic                    rollover;
  logic                    rd_csr;
  logic                    rd_cnt;
  logic                    rd_rst;
  logic [7:0]              csr_view;
  logic [7:0]              rst_view;
  logic [7:0]              next_rdata;

  // internal reset clears the block (not the watchdog-reset flag or the prescaler)
  assign int_rst = chip_reset_o;

  //////////////////////////////////////////////////////////////////////////////
  // free-running prescaler; tap is a one-cycle enable, never a derived clock
  // free-running, so a newly chosen rate starts at an arbitrary phase
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler <= '0;
    end else begin
      prescaler <= prescaler + 1'b1;
    end
  end

  // a tap's pulse marks the all-ones state of the low bits, once per period
  // changing the select while counting can give one short or long period
  always_comb begin
    case (clock_select)
      3'h0:    tick = &prescaler[0:0];
      3'h1:    tick = &prescaler[4:0];
      3'h2:    tick = &prescaler[5:0];
      3'h3:    tick = &prescaler[6:0];
      3'h4:    tick = &prescaler[7:0];
      3'h5:    tick = &prescaler[8:0];
      3'h6:    tick = &prescaler[10:0];
      3'h7:    tick = &prescaler[11:0];
      default: tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // keyed word writes; byte writes fall through and do nothing
  // a wrong key or a byte write is dropped silently; software sees no error
  assign wr_cnt = bus_wr_i && bus_word_i && bus_addr_i == SWDT_ADDR_CSR_WR
                  && bus_wdata_i[15:8] == SWDT_KEY_CNT;
  assign wr_csr = bus_wr_i && bus_word_i && bus_addr_i == SWDT_ADDR_CSR_WR
                  && bus_wdata_i[15:8] == SWDT_KEY_CSR;
  assign wr_rst = bus_wr_i && bus_word_i && bus_addr_i == SWDT_ADDR_RST_WR
                  && bus_wdata_i[15:8] == SWDT_KEY_CSR
                  && bus_wdata_i[7:0] == SWDT_RST_CLR_DATA;
  assign rd_csr = bus_rd_i && bus_addr_i == SWDT_ADDR_CSR_RD;
  assign rd_cnt = bus_rd_i && bus_addr_i == SWDT_ADDR_CNT_RD;
  assign rd_rst = bus_rd_i && bus_addr_i == SWDT_ADDR_RST_RD;
  assign rollover = counter_enable && tick && !wr_cnt && wd_counter == SWDT_CNT_MAX;

  //////////////////////////////////////////////////////////////////////////////
  // counter: write beats increment, disable holds zero
  // a write in a tick cycle loads its value and that tick is lost
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_counter <= SWDT_CNT_RESET;
    end else if (int_rst || !counter_enable) begin
      wd_counter <= SWDT_CNT_RESET;
    end else if (wr_cnt) begin
      wd_counter <= bus_wdata_i[7:0];
    end else if (tick) begin
      wd_counter <= wd_counter + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control/status: mode and enable cleared by standby, clock select kept
  // the internal reset also drops clock select, as a pin reset would
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_mode_select <= SWDT_CSR_RESET[SWDT_MODE_BIT];
      counter_enable       <= SWDT_CSR_RESET[SWDT_EN_BIT];
      clock_select         <= SWDT_CSR_RESET[2:0];
    end else if (int_rst) begin
      watchdog_mode_select <= SWDT_CSR_RESET[SWDT_MODE_BIT];
      counter_enable       <= SWDT_CSR_RESET[SWDT_EN_BIT];
      clock_select         <= SWDT_CSR_RESET[2:0];
    end else if (standby_i) begin
      watchdog_mode_select <= SWDT_CSR_RESET[SWDT_MODE_BIT];
      counter_enable       <= SWDT_CSR_RESET[SWDT_EN_BIT];
    end else if (wr_csr) begin
      watchdog_mode_select <= bus_wdata_i[SWDT_MODE_BIT];
      counter_enable       <= bus_wdata_i[SWDT_EN_BIT];
      clock_select         <= bus_wdata_i[2:0];
    end
  end

  // overflow flag: set wins over clear; clear needs a prior read of 1
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag <= 1'b0;
      overflow_seen <= 1'b0;
    end else if (int_rst || standby_i) begin
      overflow_flag <= 1'b0;
      overflow_seen <= 1'b0;
    end else if (rollover) begin
      overflow_flag <= 1'b1;
    end else begin
      if (rd_csr && overflow_flag) begin
        overflow_seen <= 1'b1;
      end
      if (wr_csr && !bus_wdata_i[SWDT_OVERFLOW_BIT] && overflow_seen) begin
        overflow_flag <= 1'b0;
        overflow_seen <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog-reset flag: only the pin reset clears it in hardware
  // set wins over a clear in the same cycle so a fresh overflow is never lost
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_reset_flag <= 1'b0;
      wd_flag_seen        <= 1'b0;
    end else if (rollover && watchdog_mode_select && counter_enable) begin
      watchdog_reset_flag <= 1'b1;
    end else begin
      if (rd_rst && watchdog_reset_flag) begin
        wd_flag_seen <= 1'b1;
      end
      if (wr_rst && wd_flag_seen) begin
        watchdog_reset_flag <= 1'b0;
        wd_flag_seen        <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal reset sequencer; the pin reset forces idle asynchronously
  // pulse length counts core clocks; RST_STATES may be shortened for quick runs
  always_comb begin
    case (state)
      SWDT_IDLE:  next_state = (rollover && watchdog_mode_select) ? SWDT_PULSE : SWDT_IDLE;
      SWDT_PULSE: next_state = (rst_count == SWDT_RST_CNT_W'(RST_STATES - 1)) ? SWDT_IDLE : SWDT_PULSE;
      default:    next_state = SWDT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state        <= SWDT_IDLE;
      rst_count    <= '0;
      chip_reset_o <= 1'b0;
    end else begin
      state        <= next_state;
      chip_reset_o <= (next_state == SWDT_PULSE);
      if (state == SWDT_PULSE) begin
        rst_count <= rst_count + 1'b1;
      end else begin
        rst_count <= '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interval interrupt follows the flag while in interval mode with counting on
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interval_irq_o <= 1'b0;
    end else begin
      interval_irq_o <= overflow_flag && !watchdog_mode_select && counter_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered byte reads; unmapped reads return zero
  // data lags the strobe by one cycle, so the cpu side samples it one edge later
  assign csr_view = {overflow_flag, watchdog_mode_select, counter_enable, SWDT_CSR_ONES, clock_select};
  assign rst_view = {watchdog_reset_flag, SWDT_RST_LOW_READ};

  always_comb begin
    next_rdata = 8'h00;
    if (rd_csr) begin
      next_rdata = csr_view;
    end else if (rd_cnt) begin
      next_rdata = wd_counter;
    end else if (rd_rst) begin
      next_rdata = rst_view;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= 8'h00;
    end else begin
      bus_rdata_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // helper: cycles the internal reset has stood high, so its length is checked exactly
  logic [SWDT_RST_CNT_W-1:0] ast_hi_cnt;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ast_hi_cnt <= '0;
    end else if (chip_reset_o) begin
      ast_hi_cnt <= ast_hi_cnt + 1'b1;
    end else begin
      ast_hi_cnt <= '0;
    end
  end

  // counter and flags
  AST_ROLL_SETS_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rollover && !int_rst && !standby_i |=> overflow_flag)
    else $error("rollover did not set overflow flag");
  AST_DISABLED_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !counter_enable |=> wd_counter == 8'h00)
    else $error("counter not zero while disabled");
  AST_WRITE_WINS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cnt && counter_enable && !int_rst && !standby_i |=> wd_counter == $past(bus_wdata_i[7:0]))
    else $error("counter write lost");
  AST_COUNT_STEP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    counter_enable && !tick && !wr_cnt && !int_rst && !standby_i |=> $stable(wd_counter))
    else $error("counter moved without a tick");
  AST_FLAG_CLEAR_GUARD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    overflow_flag && !overflow_seen && !int_rst && !standby_i |=> overflow_flag)
    else $error("overflow flag cleared without prior read");
  AST_STANDBY_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    standby_i |=> !watchdog_mode_select && !counter_enable && !overflow_flag)
    else $error("standby left upper control bits set");
  AST_BYTE_WR_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_wr_i && !bus_word_i && !int_rst |=> $stable(clock_select))
    else $error("byte write changed control/status");
  // internal reset and its flag
  AST_RST_LEN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(chip_reset_o) |-> ast_hi_cnt == SWDT_RST_CNT_W'(RST_STATES))
    else $error("internal reset length wrong");
  AST_RST_MAX: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    chip_reset_o |-> ast_hi_cnt < SWDT_RST_CNT_W'(RST_STATES))
    else $error("internal reset too long");
  AST_WDFLAG_SET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(chip_reset_o) |-> watchdog_reset_flag)
    else $error("watchdog reset without flag");
  AST_WDFLAG_KEEP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    chip_reset_o && watchdog_reset_flag |=> watchdog_reset_flag)
    else $error("own reset cleared watchdog-reset flag");
  AST_WDFLAG_CLEAR_GUARD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    watchdog_reset_flag && !wd_flag_seen |=> watchdog_reset_flag)
    else $error("watchdog-reset flag cleared without prior read");
  AST_WDFLAG_GATED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(watchdog_reset_flag) |-> $past(watchdog_mode_select) && $past(counter_enable))
    else $error("watchdog-reset flag set outside watchdog mode");
  // bus reads and interrupt
  AST_CSR_ONES: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $past(rd_csr) |-> bus_rdata_o[4:3] == 2'h3)
    else $error("reserved bits not one");
  AST_RST_ONES: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $past(rd_rst) |-> bus_rdata_o[6:0] == SWDT_RST_LOW_READ)
    else $error("reset-status low bits wrong");
  AST_CNT_READ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_cnt |=> bus_rdata_o == $past(wd_counter))
    else $error("counter read wrong");
  AST_IRQ_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    interval_irq_o |-> $past(overflow_flag) && !$past(watchdog_mode_select))
    else $error("interrupt without interval overflow");
  AST_IRQ_RAISE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    overflow_flag && !watchdog_mode_select && counter_enable |=> interval_irq_o)
    else $error("interval interrupt not raised");
  // scenario covers
  COV_ROLL: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) rollover);
  COV_WD_RESET: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(chip_reset_o));
  COV_IRQ: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(interval_irq_o));
  COV_WDFLAG_CLR: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $fell(watchdog_reset_flag));
  COV_WRITE_TICK: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) wr_cnt && tick && counter_enable);
endmodule : swdt_top

// File: swdt_cpu_model.sv
// cpu-side bus model: keyed word writes and byte reads on the peripheral bus
`timescale 1ns/1ps
module swdt_cpu_model (
  // clock and read data
  input  wire logic        core_clk_i,
  input  wire logic [7:0]  bus_rdata_i,
  // bus requests
  output logic      [15:0] bus_addr_o,
  output logic             bus_wr_o,
  output logic             bus_rd_o,
  output logic             bus_word_o,
  output logic      [15:0] bus_wdata_o
);
  // idle bus at time zero
  initial begin
    bus_addr_o  = 16'h0000;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
    bus_word_o  = 1'b0;
    bus_wdata_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one strobe cycle; released lines show the inverse so stale values never pass
  task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
    @(negedge core_clk_i);
    bus_addr_o  = addr;
    bus_wdata_o = data;
    bus_word_o  = word;
    bus_wr_o    = 1'b1;
    @(negedge core_clk_i);
    bus_wr_o    = 1'b0;
    bus_addr_o  = ~addr;
    bus_wdata_o = ~data;
  endtask : wr
  // byte read; data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(negedge core_clk_i);
    bus_addr_o = addr;
    bus_word_o = 1'b0;
    bus_rd_o   = 1'b1;
    @(negedge core_clk_i);
    bus_rd_o   = 1'b0;
    bus_addr_o = ~addr;
    data       = bus_rdata_i;
  endtask : rd
endmodule : swdt_cpu_model

// File: tb_swdt_top.sv
// testbench for the supervisor timer: register table, then timed scenarios
`timescale 1ns/1ps
module tb_swdt_top;
  import swdt_pkg::*;
  typedef struct packed {logic wr; logic word; logic [15:0] addr; logic [15:0] data; logic [7:0] exp;} swdt_row_type;
  logic         core_clk_i;
  logic         rst_n_i;
  logic         standby_i;
  logic [15:0]  bus_addr;
  logic         bus_wr;
  logic         bus_rd;
  logic         bus_word;
  logic [15:0]  bus_wdata;
  logic [7:0]   bus_rdata;
  logic         interval_irq;
  logic         chip_reset;
  logic [7:0]   rv;
  int           error_cnt = 0;
  int           check_count = 0;
  int           n;
  int           div [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
  // reset values, a refused byte write, a wrong key, a keyed write, an unmapped read
  swdt_row_type rows [10] = '{
    '{1'b0, 1'b0, 16'hffa8, 16'h0000, 8'h18}, '{1'b0, 1'b0, 16'hffa9, 16'h0000, 8'h00},
    '{1'b0, 1'b0, 16'hffab, 16'h0000, 8'h3f}, '{1'b1, 1'b0, 16'hffa8, 16'ha507, 8'h00},
    '{1'b0, 1'b0, 16'hffa8, 16'h0000, 8'h18}, '{1'b1, 1'b1, 16'hffa8, 16'hc307, 8'h00},
    '{1'b0, 1'b0, 16'hffa8, 16'h0000, 8'h18}, '{1'b1, 1'b1, 16'hffa8, 16'ha587, 8'h00},
    '{1'b0, 1'b0, 16'hffa8, 16'h0000, 8'h1f}, '{1'b0, 1'b0, 16'hffaa, 16'h0000, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////
  swdt_top swdt_top_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
    .bus_addr_i(bus_addr), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_word_i(bus_word),
    .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata), .interval_irq_o(interval_irq), .chip_reset_o(chip_reset));
  swdt_cpu_model swdt_cpu_model_i (
    .core_clk_i(core_clk_i), .bus_rdata_i(bus_rdata), .bus_addr_o(bus_addr), .bus_wr_o(bus_wr),
    .bus_rd_o(bus_rd), .bus_word_o(bus_word), .bus_wdata_o(bus_wdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask : chk_bit
  task automatic chk_cnt(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk_cnt
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    swdt_cpu_model_i.wr(a, d, 1'b1);
  endtask : w
  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    swdt_cpu_model_i.rd(a, rv);
    chk_byte(what, exp, rv);
  endtask : rchk
  // bounded wait for the internal reset to rise
  task automatic wait_chip_reset;
    for (n = 0; n < 20 && chip_reset !== 1'b1; n++) @(negedge core_clk_i);
  endtask : wait_chip_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // hang guard, sized well above the slowest prescaler sweep
  initial begin
    #(60000 * 25);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst_n_i   = 1'b0;
    standby_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) swdt_cpu_model_i.wr(rows[i].addr, rows[i].data, rows[i].word);
      else rchk("table read", rows[i].addr, rows[i].exp);
    end
    $display("test register table done");
    // each code counted over four periods; halting between codes zeroes the counter
    for (int c = 0; c < 8; c++) begin
      w(SWDT_ADDR_CSR_WR, {SWDT_KEY_CSR, 5'h04, c[2:0]});
      repeat (4 * div[c]) @(negedge core_clk_i);
      swdt_cpu_model_i.rd(SWDT_ADDR_CNT_RD, rv);
      chk_bit("count rate", 1'b1, (rv >= 8'h03) && (rv <= 8'h05));
      w(SWDT_ADDR_CSR_WR, 16'ha500);
      rchk("counter halted", SWDT_ADDR_CNT_RD, 8'h00);
    end
    $display("test clock select done");
    w(SWDT_ADDR_CSR_WR, 16'ha520);
    w(SWDT_ADDR_CSR_WR, 16'h5afe);
    for (n = 0; n < 20 && interval_irq !== 1'b1; n++) @(negedge core_clk_i);
    chk_bit("interval irq", 1'b1, interval_irq);
    rchk("csr after overflow", SWDT_ADDR_CSR_RD, 8'hb8);
    rchk("reset status in interval mode", SWDT_ADDR_RST_RD, 8'h3f);
    w(SWDT_ADDR_CSR_WR, 16'ha520);
    rchk("overflow cleared", SWDT_ADDR_CSR_RD, 8'h38);
    chk_bit("irq dropped", 1'b0, interval_irq);
    w(SWDT_ADDR_CSR_WR, 16'ha500);
    $display("test interval mode done");
    w(SWDT_ADDR_CSR_WR, 16'ha560);
    w(SWDT_ADDR_CSR_WR, 16'h5afe);
    wait_chip_reset();
    for (n = 0; n < 600 && chip_reset === 1'b1; n++) @(negedge core_clk_i);
    chk_cnt("internal reset length", 16'd518, n[15:0]);
    rchk("csr after internal reset", SWDT_ADDR_CSR_RD, 8'h18);
    rchk("flag kept", SWDT_ADDR_RST_RD, 8'hbf);
    w(SWDT_ADDR_RST_WR, 16'ha501);
    rchk("bad clear refused", SWDT_ADDR_RST_RD, 8'hbf);
    w(SWDT_ADDR_RST_WR, 16'ha500);
    rchk("flag cleared", SWDT_ADDR_RST_RD, 8'h3f);
    $display("test watchdog mode done");
    // mode set with enable clear, as software must before standby; standby drops the mode bit
    w(SWDT_ADDR_CSR_WR, 16'ha547);
    rchk("csr before standby", SWDT_ADDR_CSR_RD, 8'h5f);
    standby_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    standby_i = 1'b0;
    rchk("csr after standby", SWDT_ADDR_CSR_RD, 8'h1f);
    $display("test standby done");
    // watchdog serviced by counter rewrites well inside the overflow span
    w(SWDT_ADDR_CSR_WR, 16'ha560);
    for (int k = 0; k < 8; k++) begin
      repeat (101) @(negedge core_clk_i);
      w(SWDT_ADDR_CSR_WR, 16'h5a00);
      chk_bit("no reset while serviced", 1'b0, chip_reset);
    end
    rchk("no flag while serviced", SWDT_ADDR_RST_RD, 8'h3f);
    w(SWDT_ADDR_CSR_WR, 16'ha500);
    $display("test servicing done");
    w(SWDT_ADDR_CSR_WR, 16'ha560);
    w(SWDT_ADDR_CSR_WR, 16'h5afe);
    wait_chip_reset();
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk_bit("pin reset wins", 1'b0, chip_reset);
    rchk("flag cleared by pin", SWDT_ADDR_RST_RD, 8'h3f);
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule : tb_swdt_top
